/* rtl/acr_reg_bank.sv */
`timescale 1ns/1ps
// Contract
// - Writing one to the soft reset bit returns every register to reset.
// - The soft reset bit clears itself as soon as the reset begins.
// - Streaming addresses step down when ascend is 0, up when it is 1.
// - The separate output flag reads 1 always; reads go out on o_sdo only.
// - Mode 0 is normal, mode 3 powers the device down, 1 and 2 reserved.
// - A 16-bit read-only maker code register always returns a fixed code.
// - Address hold keeps the address fixed across a streaming transfer.
// - Alignment events are processed only while processor enable is set.
// - The alignment receiver is on only while its enable bit is set.
// - The fine step bit selects finer alignment delay steps.
// - The 4-bit delay choice selects the alignment delay, reset zero.
// - A 24-bit read-only word reports the alignment edge position.
module acr_reg_bank
    import acr_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sclk,
    input  wire logic        i_csb,
    input  wire logic        i_sdi,
    input  wire logic [23:0] i_align_edge_position,
    input  wire logic        i_align_event,
    output logic             o_sdo,
    output logic             o_chip_reset,
    output logic             o_power_down,
    output logic             o_align_input_receiver_on,
    output logic             o_align_event_processor_on,
    output logic             o_align_window_fine_step,
    output logic [3:0]       o_align_delay_choice,
    output logic             o_align_event_taken
);

    // Pin synchronisers: three stages, change once stages two and three agree
    logic [2:0] sclk_sync;
    logic [2:0] csb_sync;
    logic [2:0] sdi_sync;
    logic       sclk_q;
    logic       csb_q;
    logic       sdi_q;
    logic       evt_prev;
    logic [2:0] evt_sync;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sclk_sync <= 3'h0;
            csb_sync  <= 3'h7;
            sdi_sync  <= 3'h0;
            evt_sync  <= 3'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], i_sclk};
            csb_sync  <= {csb_sync[1:0], i_csb};
            sdi_sync  <= {sdi_sync[1:0], i_sdi};
            evt_sync  <= {evt_sync[1:0], i_align_event};
        end
    end

    // Filtered levels; stage zero feeds only stage one
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sclk_q   <= 1'b0;
            csb_q    <= 1'b1;
            sdi_q    <= 1'b0;
            evt_prev <= 1'b0;
        end else begin
            if (sclk_sync[1] == sclk_sync[2]) sclk_q <= sclk_sync[2];
            if (csb_sync[1] == csb_sync[2])   csb_q  <= csb_sync[2];
            if (sdi_sync[1] == sdi_sync[2])   sdi_q  <= sdi_sync[2];
            if (evt_sync[1] == evt_sync[2])   evt_prev <= evt_sync[2];
        end
    end

    logic sclk_prev;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) sclk_prev <= 1'b0;
        else       sclk_prev <= sclk_q;
    end

    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = sclk_q & ~sclk_prev & ~csb_q;
    assign sclk_fall = ~sclk_q & sclk_prev & ~csb_q;

    // Registers
    logic          ascend;
    logic          soft_reset_bit;
    logic [1:0]    op_mode;
    logic          addr_hold;
    logic          cfg_top_rsvd;
    acr_align_type align;
    logic [3:0]    rst_cnt;
    acr_state_type state;
    logic [4:0]    bit_cnt;
    logic [15:0]   hdr;
    logic [14:0]   addr;
    logic [7:0]    shreg;
    logic [7:0]    tx;
    logic          is_read;

    // Read decode, used for first and streamed bytes
    function automatic logic [7:0] read_reg(input logic [14:0] a);
        case (a)
            ADDR_SPI_IFACE_CFG: read_reg =
                {soft_reset_bit, 1'b0, ascend, 1'b1, 4'h0};
            ADDR_DEV_OP_CFG:      read_reg = {6'h00, op_mode};
            ADDR_MAKER_ID_LO:     read_reg = MAKER_CODE[7:0];
            ADDR_MAKER_ID_HI:     read_reg = MAKER_CODE[15:8];
            ADDR_STREAM_USER_CFG: read_reg = {7'h00, addr_hold};
            ADDR_CLK_ALIGN_CTRL:  read_reg = {cfg_top_rsvd, align};
            ADDR_EDGE_POS_0:      read_reg = i_align_edge_position[7:0];
            ADDR_EDGE_POS_1:      read_reg = i_align_edge_position[15:8];
            ADDR_EDGE_POS_2:      read_reg = i_align_edge_position[23:16];
            default:              read_reg = 8'h00;
        endcase
    endfunction

    // Next streaming address
    logic [14:0] next_addr;
    always_comb begin
        if (addr_hold)   next_addr = addr;
        else if (ascend) next_addr = addr + 15'h1;
        else             next_addr = addr - 15'h1;
    end

    logic byte_done;
    assign byte_done = (state == ST_DATA) && sclk_rise && (bit_cnt == 5'h07);

    // SPI frame state: header, data bytes, and busy during soft reset
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state   <= ST_HEADER;
            bit_cnt <= 5'h00;
            hdr     <= 16'h0000;
            addr    <= 15'h0000;
            shreg   <= 8'h00;
            is_read <= 1'b0;
            rst_cnt <= 4'h0;
        end else begin
            case (state)
                ST_HEADER: begin
                    if (soft_reset_bit) begin
                        state   <= ST_BUSY;
                        rst_cnt <= SOFT_RST_CNT;
                    end else if (csb_q) begin
                        bit_cnt <= 5'h00;
                    end else if (sclk_rise) begin
                        hdr <= {hdr[14:0], sdi_q};
                        if (bit_cnt == ADDR_LAST_BIT) begin
                            state   <= ST_DATA;
                            addr    <= {hdr[13:0], sdi_q};
                            is_read <= hdr[14];
                            bit_cnt <= 5'h00;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                ST_DATA: begin
                    if (soft_reset_bit) begin
                        state   <= ST_BUSY;
                        rst_cnt <= SOFT_RST_CNT;
                    end else if (csb_q) begin
                        state   <= ST_HEADER;
                        bit_cnt <= 5'h00;
                    end else if (sclk_rise) begin
                        shreg <= {shreg[6:0], sdi_q};
                        if (bit_cnt == 5'h07) begin
                            bit_cnt <= 5'h00;
                            addr    <= next_addr;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                ST_BUSY: begin
                    // Frames are dropped until reset time has elapsed and csb_q is high
                    bit_cnt <= 5'h00;
                    if (rst_cnt != 4'h0) rst_cnt <= rst_cnt - 4'h1;
                    else if (csb_q) state <= ST_HEADER;
                end
                default: state <= ST_HEADER;
            endcase
        end
    end

    logic [7:0] wbyte;
    assign wbyte = {shreg[6:0], sdi_q};

    logic in_reset;
    assign in_reset = (state == ST_BUSY) || soft_reset_bit;

    // Register writes; soft reset holds everything at reset values
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || in_reset) begin
            ascend       <= RST_SPI_IFACE_CFG[BIT_ASCEND];
            op_mode      <= RST_DEV_OP_CFG[MODE_MSB:0];
            addr_hold    <= RST_STREAM_USER_CFG[BIT_ADDR_HOLD];
            cfg_top_rsvd <= RST_CLK_ALIGN_CTRL[7];
            align        <= RST_CLK_ALIGN_CTRL[6:0];
        end else if (byte_done && !is_read) begin
            case (addr)
                ADDR_SPI_IFACE_CFG:   ascend    <= wbyte[BIT_ASCEND];
                ADDR_DEV_OP_CFG:      op_mode   <= wbyte[MODE_MSB:0];
                ADDR_STREAM_USER_CFG: addr_hold <= wbyte[BIT_ADDR_HOLD];
                ADDR_CLK_ALIGN_CTRL: begin
                    cfg_top_rsvd <= wbyte[7];
                    align        <= wbyte[6:0];
                end
                default: ;
            endcase
        end
    end

    // Self-clearing soft reset bit: set by write, cleared on busy entry
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || state == ST_BUSY) begin
            soft_reset_bit <= 1'b0;
        end else if (byte_done && !is_read && addr == ADDR_SPI_IFACE_CFG) begin
            soft_reset_bit <= wbyte[BIT_SOFT_RESET];
        end
    end

    // Read shifter: loaded at data start, shifted on falling SCLK
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tx    <= 8'h00;
            o_sdo <= 1'b0;
        end else if (state == ST_HEADER && sclk_rise
                     && bit_cnt == ADDR_LAST_BIT) begin
            tx <= read_reg({hdr[13:0], sdi_q});
        end else if (byte_done) begin
            tx <= read_reg(next_addr);
        end else if (state == ST_DATA && is_read && sclk_fall) begin
            o_sdo <= tx[7];
            tx    <= {tx[6:0], 1'b0};
        end else if (csb_q) begin
            o_sdo <= 1'b0;
        end
    end

    // Control outputs, all registered
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_chip_reset               <= 1'b0;
            o_power_down               <= 1'b0;
            o_align_input_receiver_on  <= 1'b0;
            o_align_event_processor_on <= 1'b0;
            o_align_window_fine_step   <= 1'b0;
            o_align_delay_choice       <= 4'h0;
            o_align_event_taken        <= 1'b0;
        end else begin
            o_chip_reset <= in_reset;
            o_power_down <= (op_mode == MODE_POWER_DOWN);
            o_align_input_receiver_on  <= align.recv_on;
            o_align_event_processor_on <= align.proc_on;
            o_align_window_fine_step   <= align.fine_step;
            o_align_delay_choice       <= align.delay_choice;
            // Event edge once stages two and three agree, so a glitch
            // on the pin cannot fire a lone pulse
            o_align_event_taken <= evt_sync[2] & evt_sync[1] & ~evt_prev
                                   & align.proc_on & align.recv_on;
        end
    end

endmodule

/* rtl/acr_pkg.sv */
package acr_pkg;
    // Register addresses (15-bit SPI address space)
    localparam logic [14:0] ADDR_SPI_IFACE_CFG   = 15'h0000;
    localparam logic [14:0] ADDR_DEV_OP_CFG      = 15'h0002;
    localparam logic [14:0] ADDR_MAKER_ID_LO     = 15'h000C;
    localparam logic [14:0] ADDR_MAKER_ID_HI     = 15'h000D;
    localparam logic [14:0] ADDR_STREAM_USER_CFG = 15'h0010;
    localparam logic [14:0] ADDR_CLK_ALIGN_CTRL  = 15'h0029;
    localparam logic [14:0] ADDR_EDGE_POS_0      = 15'h002C;
    localparam logic [14:0] ADDR_EDGE_POS_1      = 15'h002D;
    localparam logic [14:0] ADDR_EDGE_POS_2      = 15'h002E;

    // Reset values
    localparam logic [7:0] RST_SPI_IFACE_CFG   = 8'h30;
    localparam logic [7:0] RST_DEV_OP_CFG      = 8'h00;
    localparam logic [7:0] RST_STREAM_USER_CFG = 8'h00;
    localparam logic [7:0] RST_CLK_ALIGN_CTRL  = 8'h80;

    // Field positions
    localparam int BIT_SOFT_RESET  = 7;
    localparam int BIT_ASCEND      = 5;
    localparam int BIT_SEP_OUT     = 4;
    localparam int BIT_ADDR_HOLD   = 0;
    localparam int BIT_PROC_ON     = 6;
    localparam int BIT_RECV_ON     = 5;
    localparam int BIT_FINE_STEP   = 4;
    localparam int MODE_MSB        = 1;
    localparam int SEL_MSB         = 3;

    // Operating modes
    localparam logic [1:0] MODE_NORMAL     = 2'h0;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h3;

    // Maker code: value arbitrary
    localparam logic [15:0] MAKER_CODE = 16'h5A3C;

    // Internal reset time
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SOFT_RST_NS     = 750;
    localparam int SOFT_RST_CYCLES =
        (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SOFT_RST_CNT = 4'(SOFT_RST_CYCLES);

    // SPI frame layout
    localparam logic [4:0] ADDR_LAST_BIT = 5'h0F;

    typedef struct packed {
        logic       proc_on;
        logic       recv_on;
        logic       fine_step;
        logic [3:0] delay_choice;
    } acr_align_type;

    typedef enum logic [1:0] {
        ST_HEADER = 2'b00,
        ST_DATA   = 2'b01,
        ST_BUSY   = 2'b10
    } acr_state_type;
endpackage

/* tb/acr_spi_host.sv */
`timescale 1ns/1ps
// SPI mode 0 host; clock stands low outside frames
module acr_spi_host (
    input  wire logic i_sys_clk,
    input  wire logic i_sdo,
    output logic      o_sclk = 1'b0,
    output logic      o_csb  = 1'b1,
    output logic      o_sdi  = 1'b0
);
    logic [7:0] wbuf [4];
    logic [7:0] rbuf [4];
    // Eight sys clocks per half period so the synchroniser keeps up
    task automatic half();
        repeat (8) @(posedge i_sys_clk);
    endtask
    // Data set while clock low, read data taken at the rise
    task automatic bitx(input logic b, output logic q);
        o_sdi <= b;
        half();
        o_sclk <= 1'b1;
        q = i_sdo;
        half();
        o_sclk <= 1'b0;
    endtask
    // Header then n whole bytes
    task automatic frame(input logic r, input logic [14:0] a, input int n);
        logic [15:0] h;
        logic        q;
        h = {r, a};
        o_csb <= 1'b0;
        for (int i = 15; i >= 0; i--) bitx(h[i], q);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                bitx(wbuf[k][i], q);
                rbuf[k][i] = q;
            end
        end
        half();
        o_csb <= 1'b1;
        o_sdi <= ~o_sdi; // Released line shows no stale value
        half();
    endtask
endmodule

/* tb/acr_reg_bank_properties.sv */
`timescale 1ns/1ps
module acr_reg_bank_properties (
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire logic       i_csb,
    input wire logic       o_sdo,
    input wire logic       o_chip_reset,
    input wire logic       o_power_down,
    input wire logic       o_align_input_receiver_on,
    input wire logic       o_align_event_processor_on,
    input wire logic       o_align_window_fine_step,
    input wire logic [3:0] o_align_delay_choice,
    input wire logic       o_align_event_taken
);
    // All configuration outputs in one word
    wire logic [7:0] cfg;
    assign cfg = {o_power_down, o_align_input_receiver_on,
        o_align_event_processor_on, o_align_window_fine_step,
        o_align_delay_choice};
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    event_gate_a:
        assert property (o_align_event_taken |->
            o_align_event_processor_on && o_align_input_receiver_on)
        else $error("event taken while alignment off");
    taken_pulse_a:
        assert property (o_align_event_taken |=> !o_align_event_taken)
        else $error("event pulse too long");
    reset_length_a:
        assert property ($rose(o_chip_reset) |-> o_chip_reset [*8])
        else $error("soft reset too short");
    self_clear_a:
        assert property ($rose(o_chip_reset) |-> ##[8:200] !o_chip_reset)
        else $error("soft reset never clears");
    reset_clear_a:
        assert property ($rose(o_chip_reset) |-> ##[0:2] cfg == 8'h00)
        else $error("config not cleared by soft reset");
    reset_hold_a:
        assert property (o_chip_reset [*3] |-> cfg == 8'h00)
        else $error("config moved during soft reset");
    sdo_idle_a:
        assert property (i_csb [*8] |-> !o_sdo)
        else $error("serial out busy while deselected");
    cfg_steady_a:
        assert property (i_csb [*8] ##0 !o_chip_reset |=> $stable(cfg))
        else $error("config changed without access");
endmodule
bind acr_reg_bank acr_reg_bank_properties chk (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_csb(i_csb), .o_sdo(o_sdo),
    .o_chip_reset(o_chip_reset), .o_power_down(o_power_down),
    .o_align_input_receiver_on(o_align_input_receiver_on),
    .o_align_event_processor_on(o_align_event_processor_on),
    .o_align_window_fine_step(o_align_window_fine_step),
    .o_align_delay_choice(o_align_delay_choice),
    .o_align_event_taken(o_align_event_taken));

/* tb/acr_reg_bank_bench.sv */
`timescale 1ns/1ps
module acr_reg_bank_bench;
    import acr_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        evt = 1'b0;
    logic [23:0] pos = 24'h000000;
    logic        sclk, csb, sdi, sdo, crst, pdn, recv, proc, fine, tkn;
    logic [3:0]  sel;
    int          err_count = 0;
    int          check_count = 0;
    int          evs = 0;
    always #50 clk = ~clk;
    always @(posedge clk) if (tkn === 1'b1) evs++;
    acr_reg_bank uut (.i_sys_clk(clk), .i_rst(rst), .i_sclk(sclk),
        .i_csb(csb), .i_sdi(sdi), .i_align_edge_position(pos),
        .i_align_event(evt), .o_sdo(sdo), .o_chip_reset(crst),
        .o_power_down(pdn), .o_align_input_receiver_on(recv),
        .o_align_event_processor_on(proc), .o_align_window_fine_step(fine),
        .o_align_delay_choice(sel), .o_align_event_taken(tkn));
    acr_spi_host host (.i_sys_clk(clk), .i_sdo(sdo), .o_sclk(sclk),
        .o_csb(csb), .o_sdi(sdi));
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.wbuf[0] = d;
        host.frame(1'b0, a, 1);
    endtask
    task automatic rd(input logic [14:0] a, input int n);
        host.wbuf = '{default: 8'h00};
        host.frame(1'b1, a, n);
    endtask
    // Stored registers at their reset values
    task automatic t_init();
        logic [14:0] a [4] = '{15'h0000, 15'h0002, 15'h0010, 15'h0029};
        logic [7:0]  v [4] = '{8'h30, 8'h00, 8'h00, 8'h80};
        for (int i = 0; i < 4; i++) begin
            rd(a[i], 1);
            check(host.rbuf[0], v[i]);
        end
    endtask
    // Status and id streams, up, down and held
    task automatic t_stream();
        pos <= 24'hA5C3E1;
        rd(15'h002C, 3);
        check(host.rbuf[0], 8'hE1);
        check(host.rbuf[2], 8'hA5);
        wr(15'h000C, 8'hFF);
        rd(15'h000C, 2);
        check(host.rbuf[1], MAKER_CODE[15:8]);
        wr(15'h0000, 8'h00);
        rd(15'h000D, 2);
        check(host.rbuf[1], MAKER_CODE[7:0]);
        rd(15'h0000, 1);
        check(host.rbuf[0], 8'h10);
        wr(15'h0010, 8'h01);
        rd(15'h000C, 3);
        check(host.rbuf[2], MAKER_CODE[7:0]);
    endtask
    // Legal mode codes only; 1 and 2 stay unused, ends powered down
    task automatic t_modes();
        logic [1:0] m [4] = '{MODE_NORMAL, MODE_POWER_DOWN,
                              MODE_NORMAL, MODE_POWER_DOWN};
        for (int i = 0; i < 4; i++) begin
            wr(15'h0002, {6'h00, m[i]});
            check(8'(pdn), 8'(m[i] == MODE_POWER_DOWN));
        end
    endtask
    // One event edge, counted against the expected number
    task automatic pulse(input int e);
        int c;
        c = evs;
        evt <= 1'b1;
        repeat (10) @(posedge clk);
        evt <= 1'b0;
        repeat (10) @(posedge clk);
        check(8'(evs - c), 8'(e));
    endtask
    task automatic t_align();
        pulse(0);
        wr(15'h0029, 8'hA0);
        pulse(0);
        wr(15'h0029, 8'hF5);
        check({1'b0, proc, recv, fine, sel}, 8'h75);
        pulse(1);
    endtask
    // Soft reset undoes hold, mode and alignment, then clears itself
    task automatic t_soft();
        wr(15'h0000, 8'hA0);
        repeat (8) @(posedge clk);
        check({crst, pdn, recv, proc, fine, sel[2:0]}, 8'h00);
        t_init();
        pulse(0);
    endtask
    task automatic wrap_up();
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_init();
        t_stream();
        t_modes();
        t_align();
        t_soft();
        wrap_up();
    end
    // Whole run needs about 10000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule
